// ===== bench/core_bus_model.sv
// Purpose: core side of the decoder; Assumes: one request a slot; Notes: idle slots scramble addresses
`timescale 1ns/1ps
module core_bus_model (
	input wire logic clock,
	output onchip_memory_pkg::prog_req_t prog_req,
	output onchip_memory_pkg::data_req_t data_req
);
	initial {prog_req, data_req} = '0;
	// images leave the factory test words empty; a fetch there only raises the flag
	task issue(input logic [23:0] pr, input logic [17:0] dr);
		@(posedge clock);
		#1 {prog_req, data_req} = {pr, dr};
		@(posedge clock);
		#1 {prog_req, data_req} = {1'h0, ~pr[22:0], 1'h0, ~dr[16:0]};
	endtask : issue
endmodule : core_bus_model

// ===== bench/onchip_memory_map_chk.sv
// Purpose: port checks of the decoder; Assumes: answers one cycle late; Notes: bound after the module
`timescale 1ns/1ps
module onchip_memory_map_chk (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic ram_overlay_enable,
	input wire logic program_ram_in_data_enable,
	input wire onchip_memory_pkg::prog_req_t prog_req,
	input wire onchip_memory_pkg::data_req_t data_req,
	input wire onchip_memory_pkg::select_t prog_sel,
	input wire onchip_memory_pkg::select_t data_sel,
	input wire logic rom_enabled,
	input wire logic [22:0] reset_fetch_addr
);
	logic ov, en;
	logic [23:0] p;
	logic [17:0] d;
	// requests seen in reset are dropped, so no answer is tied to them
	always_ff @(posedge clock) {ov, en, p, d} <= rst_b ?
		{ram_overlay_enable, program_ram_in_data_enable, prog_req, data_req} : '0;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	property p_dual; d[17] && d[15:0] inside {[16'h0080:16'h1FFF]}
		|-> data_sel == {4'h4, d[12:11], 2'h0, d[10:0], 1'h0}; endproperty
	a_dual: assert property (p_dual) else $error("dual map");
	property p_dsgl; d[17] && d[15:13] inside {[3'h1:3'h3]}
		|-> data_sel == {3'h3, d[15:13] - 3'h1, d[12:0], 1'h0}; endproperty
	a_dsgl: assert property (p_dsgl) else $error("single map");
	property p_dhi; d[17] && d[15]
		|-> data_sel.external != en && (!en || data_sel[19:14] == {4'h7, d[14:13]}); endproperty
	a_dhi: assert property (p_dhi) else $error("upper data");
	property p_dlow; d[17] && d[15:7] == 9'h000 |-> data_sel.external; endproperty
	a_dlow: assert property (p_dlow) else $error("low data");
	property p_nrom; data_sel.region != 3'h1; endproperty
	a_nrom: assert property (p_nrom) else $error("rom in data");
	property p_povl; p[23] && ov && p[15:13] inside {[3'h1:3'h3]}
		|-> prog_sel == {3'h3, p[15:13] - 3'h1, p[12:0], 1'h0}; endproperty
	a_povl: assert property (p_povl) else $error("overlay");
	property p_prom; p[23] && !ov && p[15:14] == 2'h3
		|-> (prog_sel.region == 3'h1) == (rom_enabled && p[22:16] == 7'h00); endproperty
	a_prom: assert property (p_prom) else $error("rom map");
	property p_vec; $past(rst_b) |-> reset_fetch_addr == 23'h00FF80; endproperty
	a_vec: assert property (p_vec) else $error("boot vector");
	c_rom: cover property (prog_sel.region == 3'h1);
	c_hi: cover property (en && d[17] && d[15]);
	c_ovl: cover property (ov && p[23]);
endmodule : onchip_memory_map_chk
bind onchip_memory_map_decoder onchip_memory_map_chk chk (.*);

// ===== bench/onchip_memory_map_decoder_tb.sv
// Purpose: decoder bench; Assumes: answers one cycle late; Notes: rom and external answers are masked
`timescale 1ns/1ps
module onchip_memory_map_decoder_tb;
	logic clock, rst_b, boot_source_select, ram_overlay_enable, program_ram_in_data_enable;
	onchip_memory_pkg::prog_req_t prog_req;
	onchip_memory_pkg::data_req_t data_req;
	onchip_memory_pkg::select_t prog_sel, data_sel;
	logic rom_enabled, single_conflict, test_area_fetch;
	logic [22:0] reset_fetch_addr;
	int err_total, num_checks, cyc;
	onchip_memory_map_decoder dut (.*);
	core_bus_model core (.*);
	initial begin
		clock = 1'h0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) if (++cyc == 2000) begin
		err_total++;
		print_verdict;
	end
	task print_verdict;
		if (err_total == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : print_verdict
	task chk(input string n, input logic [22:0] e, input logic [22:0] v);
		num_checks++;
		if (v !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", n, e, v);
		end
	endtask : chk
	// block and offset are left open for rom and external answers
	task go(input logic [23:0] pr, input logic [17:0] dr, input logic [19:0] e);
		core.issue(pr, dr);
		chk("select", e, (pr[23] ? prog_sel : data_sel) & (e[19:18] == 2'h0 ? 20'hE0001 : 20'hFFFFF));
	endtask : go
	task t_data;
		go('0, {2'h2, 16'h0100}, 20'h40200);
		go('0, {2'h3, 16'h1FFF}, 20'h4CFFE);
		go('0, {2'h2, 16'h007F}, 20'h00001);
		go('0, {2'h3, 16'h7FFF}, 20'h6BFFE);
		go('0, {2'h2, 16'h8000}, 20'h00001);
		program_ram_in_data_enable = 1'h1;
		go('0, {2'h3, 16'hFFFF}, 20'h7FFFE);
	endtask : t_data
	task t_prog;
		go({1'h1, 23'h00FF80}, '0, 20'h20000);
		go({1'h1, 23'h02FF80}, '0, 20'h00001);
		go({1'h1, 23'h002000}, '0, 20'h00001);
		ram_overlay_enable = 1'h1;
		go({1'h1, 23'h7F0100}, {2'h2, 16'h4000}, 20'h40200);
		go({1'h1, 23'h000100}, {2'h3, 16'h0100}, 20'h40200);
		chk("conflict", 23'h0, single_conflict);
		go({1'h1, 23'h052000}, {2'h2, 16'h3FFF}, 20'h60000);
		chk("conflict", 23'h1, single_conflict);
	endtask : t_prog
	task t_boot;
		ram_overlay_enable = 1'h0;
		boot_source_select = 1'h1;
		chk("vector", 23'h00FF80, reset_fetch_addr);
		go({1'h1, 23'h00C000}, '0, 20'h20000);
		chk("test_fetch", 23'h0, test_area_fetch);
		go({1'h1, 23'h00FF00}, '0, 20'h20000);
		chk("test_fetch", 23'h1, test_area_fetch);
		rst_b = 1'h0;
		repeat (4) @(posedge clock);
		#1 rst_b = 1'h1;
		go({1'h1, 23'h00FF80}, '0, 20'h00001);
	endtask : t_boot
	initial begin
		{rst_b, boot_source_select, ram_overlay_enable, program_ram_in_data_enable} = 4'h0;
		repeat (4) @(posedge clock);
		#1 rst_b = 1'h1;
		t_data;
		t_prog;
		t_boot;
		print_verdict;
	end
endmodule : onchip_memory_map_decoder_tb

// ===== rtl/onchip_memory_map.svh
// Purpose: constants for the on-chip memory map decoder
// Assumes: word addresses, 16-bit program page offset plus page bits
// Notes: definitions only
`ifndef ONCHIP_MEMORY_MAP_SVH
`define ONCHIP_MEMORY_MAP_SVH
`define ROM_BASE 16'hC000
`define ROM_WORDS 17'h04000
`define BOOT_VECTOR 23'h00FF80
`define TEST_LO 16'hFF00
`define TEST_HI 16'hFF7F
`define DUAL_LO 16'h0080
`define DUAL_HI 16'h1FFF
`define DUAL_BLOCK_BITS 11
`define SINGLE_LO 16'h2000
`define SINGLE_HI 16'h7FFF
`define PROG_RAM_LO 17'h18000
`define PROG_RAM_HI 17'h1FFFF
`define SINGLE_BLOCK_BITS 13
`define COMMON_HI 16'h7FFF
`define ROM_PAGE 7'h00
`define PROG_RAM_PAGE 7'h01
`endif

// ===== rtl/onchip_memory_map_decoder.sv
// Purpose: steer program and data accesses to on-chip rom, dual and single access ram
// Assumes: core requests are on the core clock; boot_source_select is a pin
// Notes: selections are registered, so they appear one cycle after the request
`timescale 1ns/1ps
`include "onchip_memory_map.svh"
// Function
// - 16K-word rom, program space only
// - boot pin low: fetch from rom FF80h
// - dual ram: four 2K-word blocks
// - dual block: two reads or read+write
// - dual ram data 0080h-1FFFh; overlay adds program
// - single ram: seven 8K blocks, concurrent
// - single 2000h-7FFFh in program under overlay
// - program 18000h-1FFFFh in data when enabled
// - unmapped data address goes external
// - overlay: low 32K of every page maps page zero
module onchip_memory_map_decoder (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic boot_source_select,
	input wire logic ram_overlay_enable,
	input wire logic program_ram_in_data_enable,
	input wire onchip_memory_pkg::prog_req_t prog_req,
	input wire onchip_memory_pkg::data_req_t data_req,
	output onchip_memory_pkg::select_t prog_sel,
	output onchip_memory_pkg::select_t data_sel,
	output logic rom_enabled,
	output logic [22:0] reset_fetch_addr,
	output logic single_conflict,
	output logic test_area_fetch
);
	////////////////////////////////////////////////////////////////
	// block numbers are 3 bits wide; slot 3 is never produced by the map
	localparam int SINGLE_SLOTS = 8;

	logic boot_meta_reg;
	logic boot_sync_reg;
	logic [15:0] prog_low;
	logic prog_page_zero;
	logic prog_page_one;
	logic prog_common;
	logic prog_dual_hit;
	logic prog_single_low_hit;
	logic prog_single_page_hit;
	logic prog_rom_hit;
	logic prog_test_hit;
	logic data_dual_hit;
	logic data_single_low_hit;
	logic data_single_page_hit;
	logic [SINGLE_SLOTS-1:0] prog_slot_use;
	logic [SINGLE_SLOTS-1:0] data_slot_use;
	logic conflict_next;
	logic test_fetch_next;
	onchip_memory_pkg::select_t prog_next;
	onchip_memory_pkg::select_t data_next;

	////////////////////////////////////////////////////////////////
	// strap passes two flops before use
	always_ff @(posedge clock) begin
		boot_meta_reg <= boot_source_select;
		boot_sync_reg <= boot_meta_reg;
	end

	// strap captured while reset is held, frozen after release
	// hold reset long enough for the strap to cross the synchroniser
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			rom_enabled <= !boot_sync_reg;
		end
	end

	// the hardware reset vector cannot be moved, so it is a constant
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			reset_fetch_addr <= `BOOT_VECTOR;
		end
	end

	////////////////////////////////////////////////////////////////
	// program side: rom only on page 0; overlay makes low 32K common to all pages
	always_comb begin
		prog_low = prog_req.addr[15:0];
		prog_page_zero = (prog_req.addr[22:16] == `ROM_PAGE);
		prog_page_one = (prog_req.addr[22:16] == `PROG_RAM_PAGE);
		prog_common = ram_overlay_enable && (prog_low <= `COMMON_HI);
		prog_dual_hit = prog_common && (prog_low >= `DUAL_LO) && (prog_low <= `DUAL_HI);
		prog_single_low_hit = prog_common && (prog_low >= `SINGLE_LO);
		prog_single_page_hit = prog_page_one && prog_low[15];
		prog_rom_hit = rom_enabled && prog_page_zero && (prog_low >= `ROM_BASE);
		prog_test_hit = (prog_low >= `TEST_LO) && (prog_low <= `TEST_HI);
	end

	// overlay wins over page one and rom; rom offset is not decoded further
	always_comb begin
		prog_next.region = onchip_memory_pkg::region_external;
		prog_next.block = 3'h0;
		prog_next.offset = 13'h0000;
		prog_next.external = prog_req.valid;
		if (prog_dual_hit) begin
			prog_next.region = onchip_memory_pkg::region_dual;
			prog_next.block = {1'h0, prog_low[12:11]};
			prog_next.offset = {2'h0, prog_low[10:0]};
			prog_next.external = 1'h0;
		end else if (prog_single_low_hit) begin
			prog_next.region = onchip_memory_pkg::region_single;
			prog_next.block = 3'(prog_low[15:13] - 3'h1);
			prog_next.offset = prog_low[12:0];
			prog_next.external = 1'h0;
		end else if (prog_single_page_hit) begin
			prog_next.region = onchip_memory_pkg::region_single;
			prog_next.block = 3'h4 + {1'h0, prog_low[14:13]};
			prog_next.offset = prog_low[12:0];
			prog_next.external = 1'h0;
		end else if (prog_rom_hit) begin
			prog_next.region = onchip_memory_pkg::region_rom;
			prog_next.block = 3'h0;
			prog_next.offset = 13'h0000;
			prog_next.external = 1'h0;
		end
	end

	////////////////////////////////////////////////////////////////
	// data side: rom never appears here
	always_comb begin
		data_dual_hit = (data_req.addr >= `DUAL_LO) && (data_req.addr <= `DUAL_HI);
		data_single_low_hit = (data_req.addr >= `SINGLE_LO) && (data_req.addr <= `SINGLE_HI);
		data_single_page_hit = program_ram_in_data_enable && data_req.addr[15];
	end

	always_comb begin
		data_next.region = onchip_memory_pkg::region_external;
		data_next.block = 3'h0;
		data_next.offset = 13'h0000;
		data_next.external = data_req.valid;
		if (data_dual_hit) begin
			data_next.region = onchip_memory_pkg::region_dual;
			data_next.block = {1'h0, data_req.addr[12:11]};
			data_next.offset = {2'h0, data_req.addr[10:0]};
			data_next.external = 1'h0;
		end else if (data_single_low_hit) begin
			data_next.region = onchip_memory_pkg::region_single;
			data_next.block = 3'(data_req.addr[15:13] - 3'h1);
			data_next.offset = data_req.addr[12:0];
			data_next.external = 1'h0;
		end else if (data_single_page_hit) begin
			data_next.region = onchip_memory_pkg::region_single;
			data_next.block = 3'h4 + {1'h0, data_req.addr[14:13]};
			data_next.offset = data_req.addr[12:0];
			data_next.external = 1'h0;
		end
	end

	////////////////////////////////////////////////////////////////
	// dual blocks take two accesses a cycle; single blocks only one
	for (genvar slot = 0; slot < SINGLE_SLOTS; slot++) begin : g_slot
		assign prog_slot_use[slot] = prog_req.valid && (prog_next.region == onchip_memory_pkg::region_single)
			&& (prog_next.block == 3'(slot));
		assign data_slot_use[slot] = data_req.valid && (data_next.region == onchip_memory_pkg::region_single)
			&& (data_next.block == 3'(slot));
	end

	// the flags only report; stalling the core is left to the pipeline
	always_comb begin
		conflict_next = |(prog_slot_use & data_slot_use);
		test_fetch_next = prog_req.valid && (prog_next.region == onchip_memory_pkg::region_rom) && prog_test_hit;
	end

	////////////////////////////////////////////////////////////////
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			prog_sel.region <= onchip_memory_pkg::region_external;
			prog_sel.block <= 3'h0;
			prog_sel.offset <= 13'h0000;
			prog_sel.external <= 1'h0;
		end else begin
			prog_sel <= prog_next;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			data_sel.region <= onchip_memory_pkg::region_external;
			data_sel.block <= 3'h0;
			data_sel.offset <= 13'h0000;
			data_sel.external <= 1'h0;
		end else begin
			data_sel <= data_next;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			single_conflict <= 1'h0;
		end else begin
			single_conflict <= conflict_next;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			test_area_fetch <= 1'h0;
		end else begin
			test_area_fetch <= test_fetch_next;
		end
	end
endmodule : onchip_memory_map_decoder

// ===== rtl/onchip_memory_pkg.sv
// Purpose: types for the on-chip memory map decoder
// Assumes: nothing
// Notes: region codes shared with the core side
package onchip_memory_pkg;
	typedef enum logic [2:0] {region_external, region_rom, region_dual, region_single} region_t;
	typedef struct packed {
		logic valid;
		logic [22:0] addr;
	} prog_req_t;
	typedef struct packed {
		logic valid;
		logic write;
		logic [15:0] addr;
	} data_req_t;
	typedef struct packed {
		region_t region;
		logic [2:0] block;
		logic [12:0] offset;
		logic external;
	} select_t;
endpackage : onchip_memory_pkg
